// ===== include/umf_pkg.sv
// Package of constants for the multiprocessor address filter receiver
package umf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
  localparam logic [11:0] OFS_CONFIG      = 12'h004;
  localparam logic [11:0] OFS_DATA        = 12'h008;
  localparam logic [11:0] OFS_BAUD        = 12'h00C;
  localparam logic [11:0] OFS_TX_DATA     = 12'h010;

  // ==========================================================
  // Control/status field positions
  localparam int BIT_FILTER_EN  = 0;
  localparam int BIT_DOUBLE     = 1;
  localparam int BIT_FRAME_ERR  = 4;
  localparam int BIT_TX_DONE    = 6;
  localparam int BIT_RX_DONE    = 7;
  localparam int BIT_RX_NINTH   = 8;
  localparam int BIT_TX_NINTH   = 9;

  // Config field positions
  localparam int CFG_SIZE_LSB   = 0;
  localparam int CFG_STOP_BIT   = 3;
  localparam int CFG_PARITY_EN  = 4;
  localparam int CFG_RX_EN      = 5;
  localparam int CFG_TX_EN      = 6;

  // ==========================================================
  // Reset values
  localparam logic [2:0]  RST_SIZE   = 3'h3;
  localparam logic [11:0] RST_BAUD   = 12'h000;

  // ==========================================================
  // Character size codes
  localparam logic [2:0] SIZE_NINE = 3'h7;

  // ==========================================================
  // Sampling constants
  localparam logic [3:0] SPB_NORMAL   = 4'hF;
  localparam logic [3:0] SPB_DOUBLE   = 4'h7;
  localparam logic [3:0] VOTE_NORMAL  = 4'h8;
  localparam logic [3:0] VOTE_DOUBLE  = 4'h4;
  localparam logic [3:0] MID_NORMAL   = 4'h9;
  localparam logic [3:0] MID_DOUBLE   = 4'h5;
  localparam int         MIN_DATA     = 5;
  localparam int         MAX_FRAME    = 10;

endpackage

// ===== design/umf_vote.sv
// Majority vote of three samples
`timescale 1ns/1ps
module umf_vote (
  // Samples
  input  wire logic [2:0] S,
  // Result
  output wire logic       V
);
  assign V = (S[0] & S[1]) | (S[0] & S[2]) | (S[1] & S[2]);
endmodule

// ===== design/umf_tick.sv
// Sample tick divider
`timescale 1ns/1ps
module umf_tick #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST,
  // Divider value
  input  wire logic [W-1:0] DIV,
  // Sample tick
  output wire logic         TICK
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } umf_tick_st_t;
  umf_tick_st_t s_q, s_d;

  if (W < 1 || W > 16) begin : g_bad_width
    $error("umf_tick: bad width");
  end

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == '0) begin
      s_d.cnt = DIV;
    end else begin
      s_d.cnt = s_q.cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign TICK = (s_q.cnt == '0);
endmodule

// ===== design/umf_top.sv
// Serial receiver with multiprocessor address filtering and APB registers
`timescale 1ns/1ps
module umf_top #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output wire logic [31:0] PRDATA,
  output wire logic        PREADY,
  output wire logic        PSLVERR,
  // Serial lines
  input  wire logic        SERIAL_RX_LINE,
  output wire logic        SERIAL_TX_LINE
);

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_BITS  = 5'b00100,
    RX_STOP  = 5'b01000,
    RX_WAIT  = 5'b10000
  } umf_rx_st_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_DONE = 3'b100
  } umf_tx_st_t;

  typedef struct packed {
    logic              filter_en;
    logic              dbl;
    logic [2:0]        size;
    logic              stop2;
    logic              par_en;
    logic              rx_en;
    logic              tx_en;
    logic [11:0]       baud;
    logic              rx_done;
    logic              frame_err;
    logic              tx_done;
    logic              tx_ninth;
    logic [8:0]        rx_buf;
    umf_rx_st_t        rx_st;
    logic [3:0]        rx_smp;
    logic [3:0]        rx_bit;
    logic [2:0]        votes;
    logic [9:0]        rx_shift;
    logic              rx_prev;
    umf_tx_st_t        tx_st;
    logic [3:0]        tx_smp;
    logic [3:0]        tx_bit;
    logic [11:0]       tx_shift;
    logic              tx_line;
    logic [31:0]       rdata;
  } umf_state_t;

  umf_state_t s_q, s_d;

  // ==========================================================
  // Helpers
  logic tick;
  logic voted;
  logic apb_setup;
  logic apb_wr;
  logic apb_rd_data;

  if (BAUD_W != 12) begin : g_bad_width
    $error("umf_top: baud width must be 12");
  end

  // Data bits per character for a size code
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == umf_pkg::SIZE_NINE) begin
      data_bits = 4'h9;
    end else begin
      data_bits = 4'h5 + {2'b00, code[1:0]};
    end
  endfunction

  // Frame length of data plus parity
  function automatic logic [3:0] frame_bits(input logic [2:0] code, input logic par);
    frame_bits = data_bits(code) + {3'h0, par};
  endfunction

  // Known offset check
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == umf_pkg::OFS_CTRL_STATUS) || (a == umf_pkg::OFS_CONFIG) ||
             (a == umf_pkg::OFS_DATA) || (a == umf_pkg::OFS_BAUD) ||
             (a == umf_pkg::OFS_TX_DATA);
  endfunction

  // ==========================================================
  // Sample tick and vote
  umf_tick #(
    .W    (BAUD_W)
  ) u_tick (
    .CLK  (CORE_CLK),
    .RST  (RESET),
    .DIV  (s_q.baud),
    .TICK (tick)
  );

  umf_vote u_vote (
    .S ({s_q.votes[1:0], SERIAL_RX_LINE}),
    .V (voted)
  );

  assign apb_setup   = PSEL & PENABLE;
  assign apb_wr      = apb_setup & PWRITE;
  assign apb_rd_data = apb_setup & ~PWRITE & (PADDR == umf_pkg::OFS_DATA);

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0] last_smp;
    logic [3:0] vote_at;
    logic [3:0] nbits;
    logic       ftype;
    logic [8:0] word;
    logic       land;
    last_smp = s_q.dbl ? umf_pkg::SPB_DOUBLE : umf_pkg::SPB_NORMAL;
    vote_at  = s_q.dbl ? umf_pkg::VOTE_DOUBLE : umf_pkg::VOTE_NORMAL;
    nbits    = frame_bits(s_q.size, s_q.par_en);
    ftype    = 1'b0;
    word     = '0;
    land     = 1'b0;
    s_d      = s_q;

    // Receiver
    if (!s_q.rx_en) begin
      s_d.rx_st = RX_IDLE;
    end else if (tick) begin
      s_d.rx_prev = SERIAL_RX_LINE;
      s_d.rx_smp  = s_q.rx_smp + 4'h1;
      if ((s_q.rx_smp >= vote_at) && (s_q.rx_smp <= vote_at + 4'h2)) begin
        s_d.votes = {s_q.votes[1:0], SERIAL_RX_LINE};
      end
      case (s_q.rx_st)
        RX_IDLE: begin
          if (s_q.rx_prev && !SERIAL_RX_LINE) begin
            s_d.rx_st  = RX_START;
            s_d.rx_smp = 4'h2;
          end
        end
        RX_START: begin
          if (s_q.rx_smp == vote_at + 4'h2) begin
            if (voted) begin
              s_d.rx_st = RX_IDLE;
            end else begin
              s_d.rx_bit = 4'h0;
              s_d.rx_st  = RX_BITS;
            end
          end
          if (s_q.rx_smp == last_smp) begin
            s_d.rx_smp = 4'h0;
          end
        end
        RX_BITS: begin
          if (s_q.rx_smp == vote_at + 4'h2) begin
            s_d.rx_shift = {voted, s_q.rx_shift[9:1]};
            s_d.rx_bit   = s_q.rx_bit + 4'h1;
          end
          if (s_q.rx_smp == last_smp) begin
            s_d.rx_smp = 4'h0;
            if (s_q.rx_bit == nbits) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_q.rx_smp == vote_at + 4'h2) begin
            s_d.rx_st = RX_WAIT;
            word = 9'(s_q.rx_shift >> (4'hA - nbits));
            if (s_q.size == umf_pkg::SIZE_NINE) begin
              ftype = word[8];
            end else begin
              ftype = voted;
            end
            // Data frames dropped under filtering, no flags touched
            if (!(s_q.filter_en && !ftype)) begin
              s_d.rx_buf    = word;
              land          = 1'b1;
              s_d.rx_done   = 1'b1;
              s_d.frame_err = ~voted;
            end
          end
        end
        RX_WAIT: begin
          s_d.rx_st = RX_IDLE;
        end
        default: begin
          s_d.rx_st = RX_IDLE;
        end
      endcase
    end

    // Transmitter, independent of filter setting
    if (tick && s_q.tx_st != TX_IDLE) begin
      s_d.tx_smp = s_q.tx_smp + 4'h1;
    end
    case (s_q.tx_st)
      TX_IDLE: begin
        s_d.tx_line = 1'b1;
      end
      TX_SEND: begin
        if (tick && s_q.tx_smp == last_smp) begin
          s_d.tx_smp = 4'h0;
          if (s_q.tx_bit == 4'h0) begin
            s_d.tx_st = TX_DONE;
          end else begin
            s_d.tx_line  = s_q.tx_shift[0];
            s_d.tx_shift = {1'b1, s_q.tx_shift[11:1]};
            s_d.tx_bit   = s_q.tx_bit - 4'h1;
          end
        end
      end
      TX_DONE: begin
        s_d.tx_done = 1'b1;
        s_d.tx_st   = TX_IDLE;
      end
      default: begin
        s_d.tx_st = TX_IDLE;
      end
    endcase

    // Register writes
    if (apb_wr) begin
      case (PADDR)
        umf_pkg::OFS_CTRL_STATUS: begin
          s_d.filter_en = PWDATA[umf_pkg::BIT_FILTER_EN];
          s_d.dbl       = PWDATA[umf_pkg::BIT_DOUBLE];
          s_d.tx_ninth  = PWDATA[umf_pkg::BIT_TX_NINTH];
          // Write one clears transmit done, unless set this cycle
          if (PWDATA[umf_pkg::BIT_TX_DONE] && s_q.tx_st != TX_DONE) begin
            s_d.tx_done = 1'b0;
          end
        end
        umf_pkg::OFS_CONFIG: begin
          s_d.size   = PWDATA[umf_pkg::CFG_SIZE_LSB +: 3];
          s_d.stop2  = PWDATA[umf_pkg::CFG_STOP_BIT];
          s_d.par_en = PWDATA[umf_pkg::CFG_PARITY_EN];
          s_d.rx_en  = PWDATA[umf_pkg::CFG_RX_EN];
          s_d.tx_en  = PWDATA[umf_pkg::CFG_TX_EN];
        end
        umf_pkg::OFS_BAUD: begin
          s_d.baud = PWDATA[11:0];
        end
        umf_pkg::OFS_TX_DATA: begin
          if (s_q.tx_en && s_q.tx_st == TX_IDLE) begin
            s_d.tx_st  = TX_SEND;
            s_d.tx_smp = 4'h0;
            s_d.tx_bit = data_bits(s_q.size) + 4'h2 + {3'h0, s_q.stop2};
            s_d.tx_shift = 12'hFFF;
            s_d.tx_shift[0] = 1'b0;
            for (int i = 0; i < 9; i++) begin
              if (i < 8 || s_q.size == umf_pkg::SIZE_NINE) begin
                if (i < int'(data_bits(s_q.size))) begin
                  s_d.tx_shift[i+1] = (i == 8) ? s_q.tx_ninth : PWDATA[i];
                end
              end
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Reading data clears receive done, unless a frame lands now
    if (apb_rd_data && !land) begin
      s_d.rx_done = 1'b0;
    end

    // Read data
    s_d.rdata = '0;
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        umf_pkg::OFS_CTRL_STATUS: begin
          s_d.rdata[umf_pkg::BIT_FILTER_EN] = s_q.filter_en;
          s_d.rdata[umf_pkg::BIT_DOUBLE]    = s_q.dbl;
          s_d.rdata[umf_pkg::BIT_FRAME_ERR] = s_q.frame_err;
          s_d.rdata[umf_pkg::BIT_TX_DONE]   = s_q.tx_done;
          s_d.rdata[umf_pkg::BIT_RX_DONE]   = s_q.rx_done;
          s_d.rdata[umf_pkg::BIT_RX_NINTH]  = s_q.rx_buf[8];
          s_d.rdata[umf_pkg::BIT_TX_NINTH]  = s_q.tx_ninth;
        end
        umf_pkg::OFS_CONFIG: begin
          s_d.rdata[6:0] = {s_q.tx_en, s_q.rx_en, s_q.par_en, s_q.stop2, s_q.size};
        end
        umf_pkg::OFS_DATA: begin
          s_d.rdata[7:0] = s_q.rx_buf[7:0];
        end
        umf_pkg::OFS_BAUD: begin
          s_d.rdata[11:0] = s_q.baud;
        end
        default: begin
        end
      endcase
    end else if (apb_setup) begin
      s_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s_q          <= '0;
      s_q.size     <= umf_pkg::RST_SIZE;
      s_q.baud     <= umf_pkg::RST_BAUD;
      s_q.rx_st    <= RX_IDLE;
      s_q.tx_st    <= TX_IDLE;
      s_q.rx_prev  <= 1'b1;
      s_q.tx_line  <= 1'b1;
      s_q.tx_shift <= 12'hFFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA         = s_q.rdata;
  assign PREADY         = 1'b1;
  assign PSLVERR        = apb_setup & ~mapped(PADDR);
  assign SERIAL_TX_LINE = s_q.tx_line;

endmodule

// ===== test/umf_far_end.sv
// Far-end serial node model: sends frames and receives frames
`timescale 1ns/1ps
module umf_far_end (
  // Clock
  input  wire logic CLK,
  // Serial lines
  input  wire logic TX_IN,
  output logic      RX_OUT
);
  initial RX_OUT = 1'b1;

  // ==========================================================
  // Sender: start, data, type or stop bit, then second stop
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bt);
    for (int i = 0; i < nb + 3; i++) begin
      RX_OUT <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stp : 1'b1;
      repeat (bt) @(posedge CLK);
    end
  endtask

  // Short low spike on an idle line
  task automatic spike(input int n);
    RX_OUT <= 1'b0;
    repeat (n) @(posedge CLK);
    RX_OUT <= 1'b1;
    repeat (400) @(posedge CLK);
  endtask

  // ==========================================================
  // Receiver: samples each bit centre
  task automatic recv(output logic [8:0] d, input int nb, input int bt);
    d = '0;
    while (TX_IN !== 1'b0) @(posedge CLK);
    repeat (bt / 2) @(posedge CLK);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge CLK);
      d[i] = TX_IN;
    end
  endtask
endmodule

// ===== test/umf_assertions.sv
// Port checker for the address filter receiver
`timescale 1ns/1ps
module umf_assertions #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RESET,
  // APB
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [11:0]       PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Serial
  input wire logic              SERIAL_RX_LINE,
  input wire logic              SERIAL_TX_LINE
);
  logic [BAUD_W-1:0] baud_q;
  logic              dbl_q;
  logic [15:0]       low_q;
  logic              acc;
  logic              mapped;
  int                blen;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  // ==========================================================
  // Shadow state
  assign acc    = PSEL && PENABLE;
  assign mapped = PADDR inside {umf_pkg::OFS_CTRL_STATUS, umf_pkg::OFS_CONFIG,
                  umf_pkg::OFS_DATA, umf_pkg::OFS_BAUD, umf_pkg::OFS_TX_DATA};
  assign blen   = 16 * (int'(baud_q) + 1);
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      baud_q <= BAUD_W'(umf_pkg::RST_BAUD);
      dbl_q  <= 1'b0;
      low_q  <= 16'h0000;
    end else begin
      if (acc && PWRITE && PADDR == umf_pkg::OFS_BAUD) baud_q <= PWDATA[BAUD_W-1:0];
      if (acc && PWRITE && PADDR == umf_pkg::OFS_CTRL_STATUS) begin
        dbl_q <= PWDATA[umf_pkg::BIT_DOUBLE];
      end
      low_q <= SERIAL_TX_LINE ? 16'h0000 : low_q + 16'h0001;
    end
  end

  // ==========================================================
  // Properties
  property p_ready;    PREADY; endproperty
  property p_err_map;  acc && !mapped |-> PSLVERR; endproperty
  property p_err_ok;   acc && mapped |-> !PSLVERR; endproperty
  property p_err_idle; !acc |-> !PSLVERR; endproperty
  property p_unm_rd;   acc && !PWRITE && !mapped |-> PRDATA == 32'h0000_0000; endproperty
  property p_rst_out;  $fell(RESET) |-> PRDATA == 32'h0000_0000 && SERIAL_TX_LINE; endproperty
  property p_baud_rd;
    acc && !PWRITE && PADDR == umf_pkg::OFS_BAUD |-> PRDATA[BAUD_W-1:0] == baud_q;
  endproperty
  property p_tx_bit;   $rose(SERIAL_TX_LINE) && !dbl_q |-> (int'(low_q) % blen) == 0; endproperty

  a_ready:    assert property (p_ready) else $error("ready low");
  a_err_map:  assert property (p_err_map) else $error("no error on unmapped access");
  a_err_ok:   assert property (p_err_ok) else $error("error on mapped access");
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  a_unm_rd:   assert property (p_unm_rd) else $error("unmapped read not zero");
  a_rst_out:  assert property (p_rst_out) else $error("outputs wrong after reset");
  a_baud_rd:  assert property (p_baud_rd) else $error("divider readback wrong");
  a_tx_bit:   assert property (p_tx_bit) else $error("transmit bit length wrong");

  c_unmapped: cover property (acc && !mapped);
  c_tx:       cover property ($rose(SERIAL_TX_LINE));
  c_baud:     cover property (acc && !PWRITE && PADDR == umf_pkg::OFS_BAUD);
endmodule

bind umf_top umf_assertions #(.BAUD_W(BAUD_W)) umf_assertions_inst (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SERIAL_RX_LINE(SERIAL_RX_LINE), .SERIAL_TX_LINE(SERIAL_TX_LINE));

// ===== test/umf_top_tb.sv
// Testbench for the address filter receiver
`timescale 1ns/1ps
module umf_top_tb;
  logic        CORE_CLK = 1'b0;
  logic        RESET    = 1'b1;
  logic        PSEL     = 1'b0;
  logic        PENABLE  = 1'b0;
  logic        PWRITE   = 1'b0;
  logic [11:0] PADDR    = 12'h000;
  logic [31:0] PWDATA   = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        rx_line;
  logic        tx_line;
  logic [8:0]  got;
  int          num_errors = 0;
  int          tests_run  = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  umf_top #(.BAUD_W(12)) umf_top_inst (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SERIAL_RX_LINE(rx_line), .SERIAL_TX_LINE(tx_line));
  umf_far_end umf_far_end_inst (.CLK(CORE_CLK), .TX_IN(tx_line), .RX_OUT(rx_line));

  // ==========================================================
  // APB transfer and checks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CORE_CLK);
    end
    rd      = PRDATA;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r & m, e);
  endtask

  task automatic complete_run();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge CORE_CLK);
    num_errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RESET <= 1'b0;
    @(posedge CORE_CLK);
    rchk(umf_pkg::OFS_CONFIG, 32'h7F, 32'h03);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h3FF, 32'h0);
    rchk(umf_pkg::OFS_BAUD, 32'hFFF, 32'h0);
    rchk(12'h020, 32'hFFFF_FFFF, 32'h0);
    wr(12'h020, 32'hFFFF_FFFF);
    wr(umf_pkg::OFS_BAUD, 32'h1);
    rchk(umf_pkg::OFS_BAUD, 32'hFFF, 32'h1);
    wr(umf_pkg::OFS_CONFIG, 32'h67);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h1);
    umf_far_end_inst.send(9'h055, 9, 1'b1, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h190, 32'h000);
    umf_far_end_inst.send(9'h1A9, 9, 1'b1, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h190, 32'h180);
    rchk(umf_pkg::OFS_DATA, 32'hFF, 32'hA9);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h80, 32'h0);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h0);
    umf_far_end_inst.send(9'h03C, 9, 1'b1, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h190, 32'h080);
    rchk(umf_pkg::OFS_DATA, 32'hFF, 32'h3C);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h1);
    wr(umf_pkg::OFS_CONFIG, 32'h63);
    umf_far_end_inst.send(9'h0C3, 8, 1'b0, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h00);
    umf_far_end_inst.send(9'h0C3, 8, 1'b1, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h80);
    rchk(umf_pkg::OFS_DATA, 32'hFF, 32'hC3);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h0);
    umf_far_end_inst.send(9'h0C3, 8, 1'b0, 32);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h90);
    rchk(umf_pkg::OFS_DATA, 32'hFF, 32'hC3);
    for (int bt = 31; bt <= 33; bt += 2) begin
      umf_far_end_inst.send(9'h0A5, 8, 1'b1, bt);
      rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h80);
      rchk(umf_pkg::OFS_DATA, 32'hFF, 32'hA5);
    end
    umf_far_end_inst.spike(6);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h80, 32'h00);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h2);
    umf_far_end_inst.send(9'h05A, 8, 1'b1, 16);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h80);
    rchk(umf_pkg::OFS_DATA, 32'hFF, 32'h5A);
    wr(umf_pkg::OFS_CONFIG, 32'h7A);
    rchk(umf_pkg::OFS_CONFIG, 32'h7F, 32'h7A);
    umf_far_end_inst.send(9'h0D5, 8, 1'b1, 16);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h90, 32'h80);
    rchk(umf_pkg::OFS_DATA, 32'h7F, 32'h55);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h201);
    wr(umf_pkg::OFS_CONFIG, 32'h67);
    wr(umf_pkg::OFS_TX_DATA, 32'h5A);
    umf_far_end_inst.recv(got, 9, 32);
    chk({23'h0, got}, 32'h15A);
    repeat (100) @(posedge CORE_CLK);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h40, 32'h40);
    wr(umf_pkg::OFS_CTRL_STATUS, 32'h41);
    rchk(umf_pkg::OFS_CTRL_STATUS, 32'h41, 32'h01);
    complete_run();
  end
endmodule
